/* File: acl_l4_port_tcp_flag_match_test.sv */
// self-checking bench for the entry match block
`timescale 1ns/100ps
`default_nettype none
`include "alpm_defs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("mismatch %0t got %h want %h", $time, a, b); end end
module acl_l4_port_tcp_flag_match_test;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic ce = 1'b1;
    logic [3:0] awa = 4'h0, ara = 4'h0;
    logic [31:0] wd = 32'h0;
    wire awr, wr_, bv, arr, rv, hv, hl, ht, mv, mh;
    wire [1:0] br, rr;
    wire [31:0] rdt;
    wire [15:0] hp;
    wire [4:0] hf;
    int fails = 0, cmp_count = 0, i, v;
    always #12.5 aclk = ~aclk;
    alpm_parser u_par (.aclk(aclk), .hdr_valid(hv), .hdr_is_l4(hl),
        .hdr_is_tcp(ht), .hdr_dst_port(hp), .hdr_tcp_flags(hf));
    alpm_match #(.PW(16)) DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .hdr_valid(hv),
        .hdr_is_l4(hl), .hdr_is_tcp(ht), .hdr_dst_port(hp),
        .hdr_tcp_flags(hf), .match_valid(mv), .match_hit(mh));
    // ==========================================
    // bus and frame tasks
    task wr(input [3:0] a, input [31:0] d);
        @(posedge aclk);
        {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        `CHK(br, `ALPM_RESP_OKAY)
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge aclk);
        {ara, arv, rry} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        `CHK({rr, rdt}, {`ALPM_RESP_OKAY, e})
    endtask
    task frm(input t, input l, input [15:0] p, input [4:0] fl, input e);
        u_par.send(t, l, p, fl);
        #1 `CHK({mv, mh}, {1'b1, e})
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        #50000;
        fails++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ALPM_OFF_CTRL, `ALPM_CTRL_RESET);
        rd(`ALPM_OFF_RANGE, `ALPM_RANGE_RESET);
        rd(`ALPM_OFF_EXACT, 32'h0);
        frm(0, 0, 16'h1234, 5'h1F, 1);
        wr(`ALPM_OFF_EXACT, 32'h0000FFFF);
        wr(`ALPM_OFF_CTRL, 32'h00000AA9);
        frm(1, 1, 16'hFFFF, 0, 1);
        frm(0, 1, 16'hFFFE, 0, 0);
        // no l4 header, so an equal port still must not match
        frm(0, 0, 16'hFFFF, 0, 0);
        wr(`ALPM_OFF_RANGE, 32'h00500010);
        wr(`ALPM_OFF_CTRL, 32'h00000AAA);
        frm(1, 1, 16'h000F, 0, 0);
        frm(1, 1, 16'h0010, 0, 1);
        frm(0, 1, 16'h0050, 0, 1);
        frm(1, 1, 16'h0051, 0, 0);
        for (i = 0; i < 5; i++) begin
            for (v = 0; v < 2; v++) begin
                wr(`ALPM_OFF_CTRL, 32'hAA8 & ~(32'h3 << (2 + 2 * i))
                    | (v << (2 + 2 * i)));
                frm(1, 1, 0, 5'h1 << i, v[0]);
                frm(1, 1, 0, ~(5'h1 << i), !v);
                frm(0, 1, 0, 0, 1);
            end
        end
        wr(`ALPM_OFF_CTRL, 32'h00000AA5);
        rd(`ALPM_OFF_CTRL, 32'h00000AA5);
        frm(1, 1, 16'hFFFF, 5'h01, 1);
        frm(1, 1, 16'hFFFE, 5'h01, 0);
        frm(1, 1, 16'hFFFF, 5'h00, 0);
        // port mode 3 never matches
        wr(`ALPM_OFF_CTRL, 32'h00000AAB);
        frm(0, 0, 16'h0000, 5'h00, 0);
        // clock enable low: a header must leave no result and no count
        @(posedge aclk) ce <= 1'b0;
        u_par.send(1, 1, 16'h0000, 5'h00);
        #1 `CHK({mv, mh}, 2'b00)
        @(posedge aclk) ce <= 1'b1;
        // 25 hits and 17 misses were counted since reset; the clock-enable-low header is not among them
        rd(`ALPM_OFF_STAT, 32'h00110019);
        wr(`ALPM_OFF_STAT, 32'h0);
        rd(`ALPM_OFF_STAT, 32'h0);
        end_sim;
    end
endmodule // acl_l4_port_tcp_flag_match_test
`default_nettype wire

/* File: alpm_defs.vh */
// constants for the access control entry port and tcp flag match block
`ifndef ALPM_DEFS_VH
`define ALPM_DEFS_VH

// ==========================================
// register byte offsets
`define ALPM_OFF_CTRL 4'h0
`define ALPM_OFF_EXACT 4'h4
`define ALPM_OFF_RANGE 4'h8
`define ALPM_OFF_STAT 4'hC

// ==========================================
// destination port modes
`define ALPM_PMODE_ANY 2'h0
`define ALPM_PMODE_EXACT 2'h1
`define ALPM_PMODE_RANGE 2'h2

// ==========================================
// flag settings, two bits per flag
`define ALPM_FLAG_CLEAR 2'h0
`define ALPM_FLAG_SET 2'h1
`define ALPM_FLAG_ANY 2'h2

// ==========================================
// field positions and resets
`define ALPM_CTRL_PMODE_LSB 0
`define ALPM_CTRL_FLAGS_LSB 2
`define ALPM_CTRL_RESET 32'h00000AA8
`define ALPM_RANGE_RESET 32'hFFFF0000
`define ALPM_RESP_OKAY 2'h0
`define ALPM_RESP_SLVERR 2'h2

`endif

/* File: alpm_flag_cmp.v */
// tcp control flag comparator, fin syn psh ack urg
`timescale 1ns/100ps
`default_nettype none
`include "alpm_defs.vh"
module alpm_flag_cmp #(
    parameter NF = 5
) (
    // configuration, two bits per flag
    input wire [2*NF-1:0] flag_cfg,
    // frame fields
    input wire [NF-1:0] flags,
    input wire is_tcp,
    // result
    output wire flags_ok
);
    wire [NF-1:0] bit_ok;
    genvar i;
    generate
        for (i = 0; i < NF; i = i + 1) begin : g_flag
            wire [1:0] s = flag_cfg[2*i+1:2*i];
            assign bit_ok[i] = (s == `ALPM_FLAG_ANY) ||
                (s == `ALPM_FLAG_CLEAR && !flags[i]) ||
                (s == `ALPM_FLAG_SET && flags[i]);
        end
    endgenerate
    // non-tcp frames carry no flags to judge
    assign flags_ok = !is_tcp || (&bit_ok);
endmodule // alpm_flag_cmp
`default_nettype wire

/* File: alpm_match.v */
// access control entry match block with axi4-lite configuration
`timescale 1ns/100ps
`default_nettype none
`include "alpm_defs.vh"
module alpm_match #(
    parameter PW = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // parsed header from ingress
    input wire hdr_valid,
    input wire hdr_is_l4,
    input wire hdr_is_tcp,
    input wire [PW-1:0] hdr_dst_port,
    input wire [4:0] hdr_tcp_flags,
    // result
    output reg match_valid,
    output reg match_hit
);
    // ==========================================
    // configuration registers and hit and miss counters
    reg [31:0] ctrl;
    reg [31:0] exact;
    reg [31:0] range;
    reg [15:0] hit_count;
    reg [15:0] miss_count;

    // ==========================================
    // write channel, address and data taken in either order
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire [3:0] wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
    wire have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
    wire have_w = w_held || (s_axi_wvalid && s_axi_wready);
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    wire wr_ok = (wa == `ALPM_OFF_CTRL) || (wa == `ALPM_OFF_EXACT) ||
        (wa == `ALPM_OFF_RANGE) || (wa == `ALPM_OFF_STAT);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (st[b])
                    merge[8*b +: 8] = nw[8*b +: 8];
        end
    endfunction

    // ==========================================
    // match datapath
    wire port_ok;
    wire flags_ok;
    alpm_port_cmp #(.PW(PW)) u_port (
        .port_mode(ctrl[`ALPM_CTRL_PMODE_LSB +: 2]),
        .exact_port(exact[PW-1:0]),
        .range_lo(range[PW-1:0]),
        .range_hi(range[16 +: PW]),
        .dst_port(hdr_dst_port),
        .port_ok(port_ok)
    );
    alpm_flag_cmp #(.NF(5)) u_flags (
        .flag_cfg(ctrl[`ALPM_CTRL_FLAGS_LSB +: 10]),
        .flags(hdr_tcp_flags),
        .is_tcp(hdr_is_tcp),
        .flags_ok(flags_ok)
    );
    // a port criterion other than don't-care needs an l4 header to compare
    wire port_need = ctrl[1:0] != `ALPM_PMODE_ANY;
    wire hit_now = (port_ok && (hdr_is_l4 || !port_need)) &&
        flags_ok;

    always @(posedge aclk) begin
        if (!aresetn) begin
            match_valid <= 1'b0;
            match_hit <= 1'b0;
        end else if (clk_en) begin
            match_valid <= hdr_valid;
            match_hit <= hdr_valid && hit_now;
        end
    end

    // ==========================================
    // register writes and hit and miss counters
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `ALPM_CTRL_RESET;
            exact <= 32'h00000000;
            range <= `ALPM_RANGE_RESET;
            hit_count <= 16'h0000;
            miss_count <= 16'h0000;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ALPM_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (hdr_valid) begin
                if (hit_now)
                    hit_count <= hit_count + 16'h0001;
                else
                    miss_count <= miss_count + 16'h0001;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `ALPM_RESP_OKAY : `ALPM_RESP_SLVERR;
                case (wa)
                    `ALPM_OFF_CTRL: ctrl <= merge(ctrl, wd, ws) &
                        32'h00000FFF;
                    `ALPM_OFF_EXACT: exact <= merge(exact, wd, ws) &
                        32'h0000FFFF;
                    `ALPM_OFF_RANGE: range <= merge(range, wd, ws);
                    // any write to status clears both counters
                    `ALPM_OFF_STAT: begin
                        hit_count <= 16'h0000;
                        miss_count <= 16'h0000;
                    end
                    default: ;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // read channel
    reg [31:0] rd_mux;
    always @* begin
        case (s_axi_araddr)
            `ALPM_OFF_CTRL: rd_mux = ctrl;
            `ALPM_OFF_EXACT: rd_mux = exact;
            `ALPM_OFF_RANGE: rd_mux = range;
            `ALPM_OFF_STAT: rd_mux = {miss_count, hit_count};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ALPM_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 &&
                    s_axi_araddr <= `ALPM_OFF_STAT) ?
                    `ALPM_RESP_OKAY : `ALPM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // alpm_match
`default_nettype wire

/* File: alpm_match_checker.sv */
// concurrent checks on the ports of the entry match block
`timescale 1ns/100ps
`default_nettype none
`include "alpm_defs.vh"
module alpm_match_checker #(
    parameter PW = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // write side of the register bus
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // header in, result out
    input wire logic hdr_valid,
    input wire logic hdr_is_l4,
    input wire logic hdr_is_tcp,
    input wire logic [PW-1:0] hdr_dst_port,
    input wire logic [4:0] hdr_tcp_flags,
    input wire logic match_valid,
    input wire logic match_hit
);
    // ==========================================
    // shadow setup, assumes full-word writes
    logic [3:0] wa;
    logic [31:0] wd, ctl, ex, rg;
    wire f = hdr_valid & clk_en;
    wire t = f & hdr_is_tcp;
    wire [4:0] fl = hdr_tcp_flags;
    always @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
        if (!aresetn) begin
            ctl <= `ALPM_CTRL_RESET;
            ex <= 32'h00000000;
            rg <= `ALPM_RANGE_RESET;
        end else if (s_axi_bvalid && s_axi_bready) begin
            if (wa == `ALPM_OFF_CTRL) ctl <= wd;
            if (wa == `ALPM_OFF_EXACT) ex <= wd;
            if (wa == `ALPM_OFF_RANGE) rg <= wd;
        end
    end
    // ==========================================
    // assertions
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_valid_lat: assert property (f |=> match_valid)
        else $error("no result one cycle after header");
    chk_hit_only: assert property (match_hit |-> match_valid)
        else $error("hit without result strobe");
    chk_any_all: assert property (f && ctl[11:0] == 12'hAA8
        |=> match_hit) else $error("open entry missed");
    chk_exact_port: assert property (f && ctl[1:0] == 2'h1
        && hdr_dst_port != ex[PW-1:0] |=> !match_hit)
        else $error("exact port mismatch hit");
    chk_range_port: assert property (f && ctl[1:0] == 2'h2
        && (hdr_dst_port < rg[15:0] || hdr_dst_port > rg[31:16])
        |=> !match_hit) else $error("port outside range hit");
    chk_fin_flag: assert property (t && ctl[3:2] == 2'h0 && fl[0]
        |=> !match_hit) else $error("fin set hit");
    chk_syn_flag: assert property (t && ctl[5:4] == 2'h1 && !fl[1]
        |=> !match_hit) else $error("syn clear hit");
    chk_psh_flag: assert property (t && ctl[7:6] == 2'h0 && fl[2]
        |=> !match_hit) else $error("psh set hit");
    chk_ack_flag: assert property (t && ctl[9:8] == 2'h1 && !fl[3]
        |=> !match_hit) else $error("ack clear hit");
    chk_urg_flag: assert property (t && ctl[11:10] == 2'h0 && fl[4]
        |=> !match_hit) else $error("urg set hit");
endmodule // alpm_match_checker
bind alpm_match alpm_match_checker #(.PW(PW)) u_chk (.aclk, .aresetn,
    .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .hdr_valid,
    .hdr_is_l4, .hdr_is_tcp, .hdr_dst_port, .hdr_tcp_flags, .match_valid,
    .match_hit);
`default_nettype wire

/* File: alpm_parser.sv */
// ingress parser model, one header per call
`timescale 1ns/100ps
`default_nettype none
module alpm_parser (
    // clock
    input wire logic aclk,
    // parsed header
    output var logic hdr_valid,
    output var logic hdr_is_l4,
    output var logic hdr_is_tcp,
    output var logic [15:0] hdr_dst_port,
    output var logic [4:0] hdr_tcp_flags
);
    initial begin
        hdr_valid = 1'b0;
        {hdr_is_l4, hdr_is_tcp, hdr_dst_port, hdr_tcp_flags} = 23'h0;
    end
    task send(input t, input l, input [15:0] p, input [4:0] fl);
        @(posedge aclk);
        hdr_valid <= 1'b1;
        {hdr_is_l4, hdr_is_tcp, hdr_dst_port, hdr_tcp_flags} <= {l, t, p, fl};
        @(posedge aclk);
        hdr_valid <= 1'b0;
        // stale fields flipped so nothing leans on them after the strobe
        {hdr_is_l4, hdr_is_tcp, hdr_dst_port, hdr_tcp_flags} <= ~{l, t, p, fl};
    endtask
endmodule // alpm_parser
`default_nettype wire

/* File: alpm_port_cmp.v */
// destination port comparator for one entry
`timescale 1ns/100ps
`default_nettype none
`include "alpm_defs.vh"
module alpm_port_cmp #(
    parameter PW = 16
) (
    // configuration
    input wire [1:0] port_mode,
    input wire [PW-1:0] exact_port,
    input wire [PW-1:0] range_lo,
    input wire [PW-1:0] range_hi,
    // frame field
    input wire [PW-1:0] dst_port,
    // result
    output reg port_ok
);
    always @* begin
        case (port_mode)
            `ALPM_PMODE_ANY: port_ok = 1'b1;
            `ALPM_PMODE_EXACT: port_ok = (dst_port == exact_port);
            // inclusive on both ends
            `ALPM_PMODE_RANGE: port_ok = (dst_port >= range_lo) &&
                (dst_port <= range_hi);
            // undefined mode code treated as never matching
            default: port_ok = 1'b0;
        endcase
    end
endmodule // alpm_port_cmp
`default_nettype wire
